// ---- rtl/lc_pkg.sv ----
// Package with register map, field positions and enumerations of the logic cell
package lc_pkg;
    localparam logic [2:0] LC_ADDR_CONTROL_LOW   = 3'h0;
    localparam logic [2:0] LC_ADDR_CONTROL_HIGH  = 3'h1;
    localparam logic [2:0] LC_ADDR_INPUT_SELECT  = 3'h2;
    localparam logic [2:0] LC_ADDR_GATE_SEL_LOW  = 3'h3;
    localparam logic [2:0] LC_ADDR_GATE_SEL_HIGH = 3'h4;
    localparam logic [2:0] LC_ADDR_IRQ_STATUS    = 3'h5;
    localparam logic [2:0] LC_ADDR_IRQ_MASK      = 3'h6;

    localparam int LC_BIT_CELL_ENABLE   = 15;
    localparam int LC_BIT_RISE_IRQ_EN   = 11;
    localparam int LC_BIT_FALL_IRQ_EN   = 10;
    localparam int LC_BIT_PIN_OE        = 7;
    localparam int LC_BIT_OUTPUT_LEVEL  = 6;
    localparam int LC_BIT_OUTPUT_INVERT = 5;
    localparam int LC_IRQ_RISE          = 0;
    localparam int LC_IRQ_FALL          = 1;

    localparam logic [15:0] LC_CONTROL_LOW_WMASK = 16'h8ca7;
    localparam logic [15:0] LC_REG_RESET         = 16'h0000;
    localparam logic [1:0]  LC_IRQ_RESET         = 2'h0;

    typedef enum logic [2:0] {
        LC_FN_AND_OR   = 3'h0,
        LC_FN_OR_XOR   = 3'h1,
        LC_FN_AND4     = 3'h2,
        LC_FN_SR_LATCH = 3'h3,
        LC_FN_D_FF     = 3'h4,
        LC_FN_OR4      = 3'h5,
        LC_FN_JK_FF    = 3'h6,
        LC_FN_XOR4     = 3'h7
    } lc_function_t;
endpackage

// ---- rtl/lc_logic_cell.sv ----
// Configurable logic cell with selectors, OR input gates, function and edge interrupts
`timescale 1ns/1ps

// Overview of operation
// - Control registers hold enables, polarity, function
// - Software may invert gate outputs too
// - Four selectors, each picks one of eight
// - Gate-select bits route selector signals per gate
// - Each selector offers true and complement
// - Each gate ORs its enabled eight signals
// - Bits 11/10 enable rise/fall interrupts
// - Port enable bit drives output onto pin
// - Read-only bit shows current output level
module lc_logic_cell
    import lc_pkg::*;
#(
    parameter int SOURCES = 8
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic [2:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_write,
    input  wire logic               reg_read,
    output logic      [15:0]        reg_rdata,
    input  wire logic [SOURCES-1:0] data_source_0,
    input  wire logic [SOURCES-1:0] data_source_1,
    input  wire logic [SOURCES-1:0] data_source_2,
    input  wire logic [SOURCES-1:0] data_source_3,
    output logic                    cell_out,
    output logic                    cell_pin_out,
    output logic                    cell_pin_oe,
    output logic                    irq
);
    logic [15:0] control_low;
    logic [15:0] control_high;
    logic [15:0] input_select;
    logic [15:0] gate_sel_low;
    logic [15:0] gate_sel_high;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [15:0] next_control_low;
    logic [15:0] next_control_high;
    logic [15:0] next_input_select;
    logic [15:0] next_gate_sel_low;
    logic [15:0] next_gate_sel_high;
    logic [1:0]  next_irq_status;
    logic [1:0]  next_irq_mask;
    logic [15:0] next_reg_rdata;

    // Source synchronisers: three stages, change accepted when stages two and three agree
    logic [SOURCES-1:0] sync1 [4];
    logic [SOURCES-1:0] sync2 [4];
    logic [SOURCES-1:0] sync3 [4];
    logic [SOURCES-1:0] src_clean [4];
    logic [SOURCES-1:0] next_src_clean [4];
    logic [SOURCES-1:0] src_raw [4];

    logic [3:0] sel_out;
    logic [7:0] gate_in;
    logic [3:0] gate_raw;
    logic [3:0] gate;
    logic       comb_out;
    logic       next_state_bit;
    logic       state_bit;
    logic       final_out;
    logic       prev_out;
    logic       out_reg;
    logic       next_out_reg;
    lc_function_t fn;

    assign src_raw[0] = data_source_0;
    assign src_raw[1] = data_source_1;
    assign src_raw[2] = data_source_2;
    assign src_raw[3] = data_source_3;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sel
            always_comb begin
                next_src_clean[g] = src_clean[g];
                for (int b = 0; b < SOURCES; b++) begin
                    if (sync2[g][b] == sync3[g][b]) begin
                        next_src_clean[g][b] = sync3[g][b];
                    end
                end
            end
            always_ff @(posedge clk) begin
                if (reset) begin
                    sync1[g]     <= '0;
                    sync2[g]     <= '0;
                    sync3[g]     <= '0;
                    src_clean[g] <= '0;
                end else begin
                    sync1[g]     <= src_raw[g];
                    sync2[g]     <= sync1[g];
                    sync3[g]     <= sync2[g];
                    src_clean[g] <= next_src_clean[g];
                end
            end
            // Each selector picks one of its own eight sources
            assign sel_out[g] = src_clean[g][input_select[4*g +: 3]];
            // True and complement both offered to the gates
            assign gate_in[2*g]     = sel_out[g];
            assign gate_in[2*g + 1] = ~sel_out[g];
        end
        for (g = 0; g < 4; g++) begin : g_gate
            logic [7:0] gate_enables;
            // Gate n uses byte n of the gate-select pair
            assign gate_enables = (g < 2) ? gate_sel_low[8*(g%2) +: 8]
                                          : gate_sel_high[8*(g%2) +: 8];
            assign gate_raw[g] = |(gate_in & gate_enables);
            // Per-gate polarity sits in the high control register
            assign gate[g] = gate_raw[g] ^ control_high[g];
        end
    endgenerate

    assign fn = lc_function_t'(control_low[2:0]);

    always_comb begin
        comb_out       = 1'b0;
        next_state_bit = state_bit;
        case (fn)
            LC_FN_AND_OR:   comb_out = (gate[0] & gate[1]) | (gate[2] & gate[3]);
            LC_FN_OR_XOR:   comb_out = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
            LC_FN_AND4:     comb_out = &gate;
            LC_FN_OR4:      comb_out = |gate;
            LC_FN_XOR4:     comb_out = ^gate;
            LC_FN_SR_LATCH: begin
                // Set dominates reset
                if (gate[0] | gate[1]) begin
                    next_state_bit = 1'b1;
                end else if (gate[2] | gate[3]) begin
                    next_state_bit = 1'b0;
                end
                comb_out = next_state_bit;
            end
            LC_FN_D_FF: begin
                next_state_bit = gate[2] ? 1'b0 : gate[1];
                comb_out       = state_bit;
            end
            LC_FN_JK_FF: begin
                if (gate[2]) begin
                    next_state_bit = 1'b0;
                end else if (gate[0] & gate[1]) begin
                    next_state_bit = ~state_bit;
                end else if (gate[0]) begin
                    next_state_bit = 1'b1;
                end else if (gate[1]) begin
                    next_state_bit = 1'b0;
                end
                comb_out = state_bit;
            end
            default:        comb_out = 1'b0;
        endcase
        // Storage clears while disabled so re-enable starts from a known state
        if (!control_low[LC_BIT_CELL_ENABLE]) begin
            next_state_bit = 1'b0;
        end
    end

    // Disabled cell drives zero, polarity applies only when enabled
    assign final_out = control_low[LC_BIT_CELL_ENABLE]
                     ? (comb_out ^ control_low[LC_BIT_OUTPUT_INVERT])
                     : 1'b0;
    assign next_out_reg = final_out;

    always_comb begin
        next_control_low  = control_low;
        next_control_high = control_high;
        next_input_select = input_select;
        next_gate_sel_low = gate_sel_low;
        next_gate_sel_high = gate_sel_high;
        next_irq_mask     = irq_mask;
        next_irq_status   = irq_status;
        if (reg_write) begin
            case (reg_addr)
                LC_ADDR_CONTROL_LOW:   next_control_low =
                    reg_wdata & LC_CONTROL_LOW_WMASK;
                LC_ADDR_CONTROL_HIGH:  next_control_high = {12'h000, reg_wdata[3:0]};
                LC_ADDR_INPUT_SELECT:  next_input_select = reg_wdata & 16'h7777;
                LC_ADDR_GATE_SEL_LOW:  next_gate_sel_low = reg_wdata;
                LC_ADDR_GATE_SEL_HIGH: next_gate_sel_high = reg_wdata;
                LC_ADDR_IRQ_STATUS:    next_irq_status = irq_status & ~reg_wdata[1:0];
                LC_ADDR_IRQ_MASK:      next_irq_mask = reg_wdata[1:0];
                default:               next_irq_mask = irq_mask;
            endcase
        end
        // Edge events set after the clear so a same-cycle event is kept
        if (control_low[LC_BIT_RISE_IRQ_EN] && out_reg && !prev_out) begin
            next_irq_status[LC_IRQ_RISE] = 1'b1;
        end
        if (control_low[LC_BIT_FALL_IRQ_EN] && !out_reg && prev_out) begin
            next_irq_status[LC_IRQ_FALL] = 1'b1;
        end
    end

    always_comb begin
        next_reg_rdata = 16'h0000;
        if (reg_read) begin
            case (reg_addr)
                LC_ADDR_CONTROL_LOW: begin
                    next_reg_rdata = control_low;
                    next_reg_rdata[LC_BIT_OUTPUT_LEVEL] = out_reg;
                end
                LC_ADDR_CONTROL_HIGH:  next_reg_rdata = control_high;
                LC_ADDR_INPUT_SELECT:  next_reg_rdata = input_select;
                LC_ADDR_GATE_SEL_LOW:  next_reg_rdata = gate_sel_low;
                LC_ADDR_GATE_SEL_HIGH: next_reg_rdata = gate_sel_high;
                LC_ADDR_IRQ_STATUS:    next_reg_rdata = {14'h0000, irq_status};
                LC_ADDR_IRQ_MASK:      next_reg_rdata = {14'h0000, irq_mask};
                default:               next_reg_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            control_low   <= LC_REG_RESET;
            control_high  <= LC_REG_RESET;
            input_select  <= LC_REG_RESET;
            gate_sel_low  <= LC_REG_RESET;
            gate_sel_high <= LC_REG_RESET;
            irq_status    <= LC_IRQ_RESET;
            irq_mask      <= LC_IRQ_RESET;
            reg_rdata     <= LC_REG_RESET;
            state_bit     <= 1'b0;
            out_reg       <= 1'b0;
            prev_out      <= 1'b0;
        end else begin
            control_low   <= next_control_low;
            control_high  <= next_control_high;
            input_select  <= next_input_select;
            gate_sel_low  <= next_gate_sel_low;
            gate_sel_high <= next_gate_sel_high;
            irq_status    <= next_irq_status;
            irq_mask      <= next_irq_mask;
            reg_rdata     <= next_reg_rdata;
            state_bit     <= next_state_bit;
            out_reg       <= next_out_reg;
            prev_out      <= out_reg;
        end
    end

    assign cell_out     = out_reg;
    assign cell_pin_out = control_low[LC_BIT_PIN_OE] & out_reg;
    assign cell_pin_oe  = control_low[LC_BIT_PIN_OE];
    assign irq          = |(irq_status & irq_mask);
endmodule

// ---- verification/lc_checker.sv ----
// Port checker for the logic cell
`timescale 1ns/1ps
module lc_checker
    import lc_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [2:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic        cell_out,
    input wire logic        cell_pin_out,
    input wire logic        cell_pin_oe,
    input wire logic        irq
);
    logic [15:0] ctl;
    logic [1:0]  msk;

    // Shadow of the control and mask words, seen only through bus writes
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl <= 16'h0000;
            msk <= 2'h0;
        end else if (reg_write && reg_addr == LC_ADDR_CONTROL_LOW) begin
            ctl <= reg_wdata;
        end else if (reg_write && reg_addr == LC_ADDR_IRQ_MASK) begin
            msk <= reg_wdata[1:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_rise;
        $rose(cell_out) && ctl[11] && msk[0];
    endsequence
    sequence s_fall;
        $fell(cell_out) && ctl[10] && msk[1];
    endsequence

    a_disabled_low: assert property (!ctl[15] |=> !cell_out)
        else $error("cell output high while disabled");
    a_rise_irq: assert property (s_rise |-> ##[1:2] irq)
        else $error("no interrupt after rising output");
    a_fall_irq: assert property (s_fall |-> ##[1:2] irq)
        else $error("no interrupt after falling output");
    a_pin_gated: assert property (!cell_pin_oe |-> !cell_pin_out)
        else $error("pin driven while output disabled");
    a_pin_oe_bit: assert property (cell_pin_oe == ctl[7] || cell_pin_oe == $past(ctl[7]))
        else $error("pin enable differs from control bit");
    a_read_idle: assert property (!reg_read |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    a_level_bit: assert property (reg_read && reg_addr == LC_ADDR_CONTROL_LOW
        |=> reg_rdata[6] == $past(cell_out))
        else $error("level bit differs from output");
    a_ctl_fields: assert property (reg_read && reg_addr == LC_ADDR_CONTROL_LOW
        |=> (reg_rdata & ~16'h8ce7) == 16'h0000)
        else $error("unimplemented control bits read high");
    a_mask_off: assert property (reg_write && reg_addr == LC_ADDR_IRQ_MASK
        && reg_wdata[1:0] == 2'h0 |=> !irq)
        else $error("interrupt high with mask cleared");
endmodule

bind lc_logic_cell lc_checker lc_checker_i (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cell_out(cell_out), .cell_pin_out(cell_pin_out), .cell_pin_oe(cell_pin_oe), .irq(irq)
);

// ---- verification/lc_logic_cell_tb.sv ----
// Self-checking bench for the logic cell
`timescale 1ns/1ps
module lc_logic_cell_tb
    import lc_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [7:0]  src [4] = '{default: 8'h00};
    logic [15:0] reg_rdata;
    logic        cell_out, cell_pin_out, cell_pin_oe, irq;
    int          num_errors = 0, tests_run = 0, cycles = 0;

    always #5 clk = ~clk;

    lc_logic_cell lc_logic_cell_i (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .data_source_0(src[0]), .data_source_1(src[1]), .data_source_2(src[2]),
        .data_source_3(src[3]), .cell_out(cell_out), .cell_pin_out(cell_pin_out),
        .cell_pin_oe(cell_pin_oe), .irq(irq)
    );

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    // Gate g sees source 5 of selector g; wait covers synchroniser and output flop
    task automatic drive(input logic [3:0] p);
        @(posedge clk);
        for (int g = 0; g < 4; g++) src[g] <= {2'h0, p[g], 5'h00};
        repeat (8) @(posedge clk);
        #1;
    endtask

    function automatic logic fn_exp(input logic [2:0] f, input logic [3:0] g);
        case (f)
            3'h0: return (g[0] & g[1]) | (g[2] & g[3]);
            3'h1: return (g[0] | g[1]) ^ (g[2] | g[3]);
            3'h2: return &g;
            3'h5: return |g;
            default: return ^g;
        endcase
    endfunction

    task automatic t_regs();
        logic [15:0] d;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d);
            chk("reset value", 16'h0000, d);
        end
        wr(LC_ADDR_CONTROL_LOW, 16'hffff);
        rd(LC_ADDR_CONTROL_LOW, d);
        chk("control low", 16'h8ca7, d & 16'hffbf);
        wr(3'h7, 16'hffff);
        rd(3'h7, d);
        chk("unmapped", 16'h0000, d);
        wr(LC_ADDR_CONTROL_LOW, 16'h0000);
        $display("test regs done");
    endtask

    // Pass 1 inverts gate 0 and the output, pass 2 uses the complement of selector 0
    task automatic t_func();
        logic [2:0]  fl [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h7};
        logic [15:0] d;
        logic        e;
        wr(LC_ADDR_INPUT_SELECT, 16'h5555);
        wr(LC_ADDR_GATE_SEL_HIGH, 16'h4010);
        for (int i = 0; i < 3; i++) begin
            wr(LC_ADDR_GATE_SEL_LOW, i == 2 ? 16'h0402 : 16'h0401);
            wr(LC_ADDR_CONTROL_HIGH, i == 1 ? 16'h0001 : 16'h0000);
            for (int k = 0; k < 5; k++) begin
                wr(LC_ADDR_CONTROL_LOW, 16'h8000 | (i == 1 ? 16'h0020 : 16'h0000)
                   | 16'(fl[k]));
                for (int p = 0; p < 16; p++) begin
                    drive(4'(p));
                    e = fn_exp(fl[k], 4'(p) ^ {3'h0, i != 0}) ^ (i == 1);
                    chk("cell out", 16'(e), 16'(cell_out));
                    rd(LC_ADDR_CONTROL_LOW, d);
                    chk("level bit", 16'(e), 16'(d[6]));
                end
            end
        end
        wr(LC_ADDR_CONTROL_LOW, 16'h0025);
        drive(4'hf);
        chk("disabled out", 16'h0000, 16'(cell_out));
        $display("test func done");
    endtask

    task automatic t_irq();
        logic [15:0] d;
        wr(LC_ADDR_GATE_SEL_LOW, 16'h0401);
        drive(4'h0);
        wr(LC_ADDR_IRQ_STATUS, 16'h0003);
        wr(LC_ADDR_IRQ_MASK, 16'h0003);
        wr(LC_ADDR_CONTROL_LOW, 16'h8c85);
        drive(4'h1);
        chk("pin out", 16'h0001, 16'(cell_pin_out));
        chk("pin oe", 16'h0001, 16'(cell_pin_oe));
        rd(LC_ADDR_IRQ_STATUS, d);
        chk("rise status", 16'h0001, d);
        chk("irq rise", 16'h0001, 16'(irq));
        wr(LC_ADDR_IRQ_STATUS, 16'h0001);
        drive(4'h0);
        rd(LC_ADDR_IRQ_STATUS, d);
        chk("fall status", 16'h0002, d);
        wr(LC_ADDR_IRQ_MASK, 16'h0001);
        chk("irq masked", 16'h0000, 16'(irq));
        wr(LC_ADDR_IRQ_STATUS, 16'h0003);
        wr(LC_ADDR_CONTROL_LOW, 16'h8805);
        drive(4'h1);
        chk("pin oe off", 16'h0000, 16'(cell_pin_oe));
        chk("pin out off", 16'h0000, 16'(cell_pin_out));
        drive(4'h0);
        rd(LC_ADDR_IRQ_STATUS, d);
        chk("rise only", 16'h0001, d);
        wr(LC_ADDR_IRQ_MASK, 16'h0000);
        $display("test irq done");
    endtask

    // Storage functions: latch and JK driven through set, hold and clear, flip-flop through data and reset
    task automatic t_seq();
        wr(LC_ADDR_CONTROL_LOW, 16'h8003);
        drive(4'h1);
        chk("latch set", 16'h0001, 16'(cell_out));
        drive(4'h0);
        chk("latch hold", 16'h0001, 16'(cell_out));
        drive(4'h4);
        chk("latch clear", 16'h0000, 16'(cell_out));
        wr(LC_ADDR_CONTROL_LOW, 16'h8004);
        drive(4'h2);
        chk("dff data", 16'h0001, 16'(cell_out));
        drive(4'h6);
        chk("dff reset", 16'h0000, 16'(cell_out));
        wr(LC_ADDR_CONTROL_LOW, 16'h8006);
        drive(4'h1);
        chk("jk set", 16'h0001, 16'(cell_out));
        drive(4'h0);
        chk("jk hold", 16'h0001, 16'(cell_out));
        drive(4'h2);
        chk("jk clear", 16'h0000, 16'(cell_out));
        wr(LC_ADDR_CONTROL_LOW, 16'h0006);
        drive(4'h1);
        chk("seq disabled", 16'h0000, 16'(cell_out));
        $display("test seq done");
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_func();
        t_irq();
        t_seq();
        give_verdict();
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            give_verdict();
        end
    end
endmodule
